// File: hdl/rcl_pkg.sv
// Package for the regulator control logic: register map, field layout,
// reset values, timing counts and the state record of the block.
// Assumes a 100 MHz APB clock shared with the power sequencer.
package rcl_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_EN     = 8'h04;
  localparam logic [7:0] ADDR_ENSRC  = 8'h08;
  localparam logic [7:0] ADDR_SELSRC = 8'h0C;
  localparam logic [3:0] PAGE_BUCK   = 4'h1;
  localparam logic [3:0] PAGE_LDO    = 4'h2;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_EVENT  = 8'h34;

  // ==========================================================================
  // Field positions
  localparam int CTRL_SD    = 0;
  localparam int CTRL_SLOW  = 1;
  localparam int CTRL_DISCH = 2;
  localparam int CTRL_VTT   = 3;
  localparam int CTRL_TERMINATION_REFERENCE_OUT  = 4;
  localparam int CTRL_AON   = 5;
  localparam int CTRL_FCM1  = 6;
  localparam int CTRL_FCM2  = 7;
  localparam int CTRL_SLEW  = 8;
  localparam int CFG_VA     = 0;
  localparam int CFG_VB     = 8;
  localparam int CFG_SLA    = 16;
  localparam int CFG_SLB    = 17;
  localparam int CFG_MODE   = 18;
  localparam int CFG_PDD    = 18;
  localparam int CFG_ILIM   = 20;
  localparam int EV_LIM     = 0;
  localparam int EV_RDY     = 1;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_00C1;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;

  // ==========================================================================
  // Timing
  localparam int CLK_NS        = 10;
  localparam int SLEW_UNIT_NS  = 1000;
  localparam int SLEW_UNIT_CYC = (SLEW_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int OC_EVENT_MS   = 10;
  localparam int OC_SD_MS      = 200;
  localparam int OC_EVENT_CYC  = OC_EVENT_MS * 1000000 / CLK_NS;
  localparam int OC_SD_CYC     = OC_SD_MS * 1000000 / CLK_NS;
  localparam int OC_CNT_W      = 25;

  // ==========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [31:0]               prdata;
    logic [31:0]               ctrl;
    logic [3:0]                buck_en;
    logic [3:0]                ldo_en;
    logic [3:0]                buck_sel;
    logic [3:0]                ldo_sel;
    logic [15:0]               en_src;
    logic [15:0]               sel_src;
    logic [3:0][31:0]          buck_cfg;
    logic [3:0][31:0]          ldo_cfg;
    logic [3:0][7:0]           vcode;
    logic [3:0]                run;
    logic [1:0][2:0]           gpi_s;
    logic [2:0]                gpi_q;
    logic [1:0][3:0]           ilim_s;
    logic [1:0][3:0]           ovp_s;
    logic [7:0]                seq_en_q;
    logic [7:0]                seq_sel_q;
    logic [3:0][OC_CNT_W-1:0]  oc_cnt;
    logic [15:0]               slew_cnt;
    logic                      all_rdy_q;
    logic [1:0]                ev;
    logic                      ev_lim_p;
    logic                      ev_rdy_p;
  } rcl_state_t;

endpackage

// File: hdl/rcl_regulator_ctrl.sv
// Regulator control logic: enables, A/B settings, buck voltage slewing,
// LDO over-current timing and the analog takeover of GPIO0 and GPIO1.
// Assumes GPI levels arrive already polarity-corrected and the sequencer
// and power-mode inputs are on pclk; comparators are asynchronous.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Analog use of pin 0 or 1 disables ordinary GPI behaviour there; the code masks only GPI1, and only while pin 1 is analog.
// - Buck voltage fields are writable only in ACTIVE mode.
// - Every regulator holds settings A and B, each with voltage and sleep bit.
// - A/B choice comes from select bit, sequencer or an assigned GPI.
// - LDO enable comes from register bit, assigned GPI or sequencer.
// - An LDO sleeps while the setting its sleep-link names is active.
// - LDO1 may be always on, even in RESET mode.
// - Over 10 ms continuous over-current raises an event; live state readable.
// - Over 200 ms with shutdown enabled clears the LDO enable bit.
// - Over-voltage switches in the pull-down unless disabled per LDO.
// - Buck codes step 10 mV, Buck3 20 mV per code.
// - Buck enable comes from register bit, assigned GPI or sequencer.
// - Active buck setting follows select bit, GPI or sequencer.
// - Voltage changes step one code per shared slew step time.
// - Ramp-ready event fires once all bucks reach target codes.
// - Slow-start bit selects slow ramp, else jump to target.
// - With discharge enabled, a switched-off buck ramps its code down.
// - Each buck has a programmable peak current limit field.
// - Each buck mode field selects PWM, PFM or auto.
// - A buck sleeps while a setting with its sleep bit set is active.
// - Buck1 and Buck2 full-current bit 1 full, 0 half current.
// - GPI edges set and clear the select bit.
// - GPI edges set and clear the enable bit; sequencer loses control.
module rcl_regulator_ctrl #(
  parameter int unsigned OC_EVENT_CYC = rcl_pkg::OC_EVENT_CYC,
  parameter int unsigned OC_SD_CYC    = rcl_pkg::OC_SD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_active,
  input  wire logic        mode_reset,
  input  wire logic [7:0]  seq_enable,
  input  wire logic [7:0]  seq_select,
  input  wire logic [2:0]  gpi_level,
  input  wire logic [3:0]  ldo_ilim_cmp,
  input  wire logic [3:0]  ldo_ovp_cmp,
  output logic [3:0]       buck_enable_out,
  output logic [31:0]      buck_vcode,
  output logic [3:0]       buck_sleep,
  output logic [7:0]       buck_op_mode,
  output logic [7:0]       switcher_current_limit,
  output logic             slow_startup_select,
  output logic             switcher1_full_current,
  output logic             switcher2_full_current,
  output logic [3:0]       ldo_enable_out,
  output logic [31:0]      ldo_vcode,
  output logic [3:0]       ldo_sleep,
  output logic [3:0]       ldo_pulldown,
  output logic             gpio0_analog,
  output logic             gpio1_analog,
  output logic             ramp_ready_event,
  output logic             linreg_overcurrent_event
);

  localparam int CW = rcl_pkg::OC_CNT_W;
  localparam logic [CW-1:0] EV_M1 = CW'(OC_EVENT_CYC - 1);
  localparam logic [CW-1:0] SD_M1 = CW'(OC_SD_CYC - 1);
  localparam logic [CW-1:0] SD_MX = CW'(OC_SD_CYC);

  rcl_pkg::rcl_state_t s;
  rcl_pkg::rcl_state_t next_s;
  logic [3:0]          on;
  logic [3:0][7:0]     tgt;
  logic [3:0]          at_tgt;
  logic [2:0]          gpi_m;
  logic [2:0]          gpi_p;
  logic                wr;

  // ==========================================================================
  // Helpers

  // Known word-aligned addresses; everything else answers with pslverr.
  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a[1:0] == 2'b00) &&
             (a[7:4] == rcl_pkg::PAGE_BUCK || a[7:4] == rcl_pkg::PAGE_LDO ||
              a <= rcl_pkg::ADDR_SELSRC || a == rcl_pkg::ADDR_STATUS ||
              a == rcl_pkg::ADDR_EVENT);
  endfunction

  // Edge of the chosen control source: 0 selects the sequencer, 1..3 a GPI.
  function automatic logic [1:0] ctl_edge(input logic [1:0] src, input logic [2:0] gn,
                                          input logic [2:0] gp, input logic sn, input logic sp);
    logic now;
    logic prev;
    now  = (src == 2'd0) ? sn : gn[src - 2'd1];
    prev = (src == 2'd0) ? sp : gp[src - 2'd1];
    ctl_edge = {now & ~prev, ~now & prev};
  endfunction

  // One code toward the target per call.
  function automatic logic [7:0] step_to(input logic [7:0] cur, input logic [7:0] t);
    if (cur < t) begin
      step_to = cur + 8'd1;
    end else if (cur > t) begin
      step_to = cur - 8'd1;
    end else begin
      step_to = cur;
    end
  endfunction

  // ==========================================================================
  // Per-regulator targets and outputs

  // Pin 1 is masked when it carries the reference, so its edges never act.
  assign gpi_m = s.gpi_s[1] & ~{2'b00, gpio1_analog};
  assign gpi_p = s.gpi_q & ~{2'b00, gpio1_analog};
  assign wr    = psel && penable && pwrite;

  // Target code follows the active setting; a switched-off buck aims at 0.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_buck
      assign on[g]     = s.buck_en[g] & ~mode_reset;
      assign tgt[g]    = s.buck_sel[g] ? s.buck_cfg[g][rcl_pkg::CFG_VB+:8]
                                       : s.buck_cfg[g][rcl_pkg::CFG_VA+:8];
      assign at_tgt[g] = s.vcode[g] == (on[g] ? tgt[g] : 8'h00);
      assign buck_enable_out[g] = on[g] | (s.ctrl[rcl_pkg::CTRL_DISCH] & (s.vcode[g] != 8'h00));
      assign buck_sleep[g] = s.buck_sel[g] ? s.buck_cfg[g][rcl_pkg::CFG_SLB]
                                           : s.buck_cfg[g][rcl_pkg::CFG_SLA];
      assign buck_op_mode[2*g+:2] = s.buck_cfg[g][rcl_pkg::CFG_MODE+:2];
      assign switcher_current_limit[2*g+:2] = s.buck_cfg[g][rcl_pkg::CFG_ILIM+:2];
      assign buck_vcode[8*g+:8] = s.vcode[g];
      assign ldo_vcode[8*g+:8] = s.ldo_sel[g] ? s.ldo_cfg[g][rcl_pkg::CFG_VB+:8]
                                              : s.ldo_cfg[g][rcl_pkg::CFG_VA+:8];
      assign ldo_sleep[g] = s.ldo_sel[g] ? s.ldo_cfg[g][rcl_pkg::CFG_SLB]
                                         : s.ldo_cfg[g][rcl_pkg::CFG_SLA];
      assign ldo_pulldown[g] = s.ovp_s[1][g] & ~s.ldo_cfg[g][rcl_pkg::CFG_PDD];
    end
  endgenerate

  // ==========================================================================
  // Remaining outputs

  // LDO1 alone survives RESET mode when the always-on bit is set.
  assign ldo_enable_out = (s.ldo_en & {4{~mode_reset}}) |
                          {3'b000, s.ctrl[rcl_pkg::CTRL_AON]};
  assign slow_startup_select    = s.ctrl[rcl_pkg::CTRL_SLOW];
  assign switcher1_full_current = s.ctrl[rcl_pkg::CTRL_FCM1];
  assign switcher2_full_current = s.ctrl[rcl_pkg::CTRL_FCM2];
  assign gpio0_analog = s.ctrl[rcl_pkg::CTRL_VTT] | s.ctrl[rcl_pkg::CTRL_TERMINATION_REFERENCE_OUT];
  assign gpio1_analog = s.ctrl[rcl_pkg::CTRL_TERMINATION_REFERENCE_OUT];
  assign prdata       = s.prdata;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !map_ok(paddr);
  assign ramp_ready_event         = s.ev_rdy_p;
  assign linreg_overcurrent_event = s.ev_lim_p;

  // ==========================================================================
  // Next-state logic

  // Hardware events are applied after the bus write so a set wins a clear.
  always_comb begin
    logic [7:0] en_v;
    logic [7:0] sel_v;
    logic [1:0] e;
    logic       tick;
    logic [1:0] bi;
    en_v  = 8'h00;
    sel_v = 8'h00;
    e     = 2'b00;
    bi    = paddr[3:2];
    tick  = (s.slew_cnt == 16'h0000);
    next_s          = s;
    next_s.ev_lim_p = 1'b0;
    next_s.ev_rdy_p = 1'b0;
    next_s.gpi_s    = {s.gpi_s[0], gpi_level};
    next_s.ilim_s   = {s.ilim_s[0], ldo_ilim_cmp};
    next_s.ovp_s    = {s.ovp_s[0], ldo_ovp_cmp};
    next_s.gpi_q    = gpi_m;
    next_s.seq_en_q  = seq_enable;
    next_s.seq_sel_q = seq_select;

    // Read data is captured in the setup cycle, so pready can stay high.
    if (psel && !penable) begin
      if (paddr == rcl_pkg::ADDR_CTRL) begin
        next_s.prdata = s.ctrl;
      end else if (paddr == rcl_pkg::ADDR_EN) begin
        next_s.prdata = {16'h0000, s.ldo_sel, s.buck_sel, s.ldo_en, s.buck_en};
      end else if (paddr == rcl_pkg::ADDR_ENSRC) begin
        next_s.prdata = {16'h0000, s.en_src};
      end else if (paddr == rcl_pkg::ADDR_SELSRC) begin
        next_s.prdata = {16'h0000, s.sel_src};
      end else if (paddr[7:4] == rcl_pkg::PAGE_BUCK && map_ok(paddr)) begin
        next_s.prdata = s.buck_cfg[bi];
      end else if (paddr[7:4] == rcl_pkg::PAGE_LDO && map_ok(paddr)) begin
        next_s.prdata = s.ldo_cfg[bi];
      end else if (paddr == rcl_pkg::ADDR_STATUS) begin
        next_s.prdata = {23'h00_0000, &at_tgt, at_tgt, s.ilim_s[1]};
      end else if (paddr == rcl_pkg::ADDR_EVENT) begin
        next_s.prdata = {30'h0000_0000, s.ev};
      end else begin
        next_s.prdata = 32'h0000_0000;
      end
    end

    // Register writes take effect at the access-phase edge.
    if (wr) begin
      if (paddr == rcl_pkg::ADDR_CTRL) begin
        next_s.ctrl = {20'h0_0000, pwdata[11:0]};
      end else if (paddr == rcl_pkg::ADDR_EN) begin
        {next_s.ldo_sel, next_s.buck_sel, next_s.ldo_en, next_s.buck_en} = pwdata[15:0];
      end else if (paddr == rcl_pkg::ADDR_ENSRC) begin
        next_s.en_src = pwdata[15:0];
      end else if (paddr == rcl_pkg::ADDR_SELSRC) begin
        next_s.sel_src = pwdata[15:0];
      end else if (paddr[7:4] == rcl_pkg::PAGE_BUCK && map_ok(paddr)) begin
        next_s.buck_cfg[bi] = {10'h000, pwdata[21:16],
                               mode_active ? pwdata[15:0] : s.buck_cfg[bi][15:0]};
      end else if (paddr[7:4] == rcl_pkg::PAGE_LDO && map_ok(paddr)) begin
        next_s.ldo_cfg[bi] = {13'h0000, pwdata[18:0]};
      end else if (paddr == rcl_pkg::ADDR_EVENT) begin
        next_s.ev = s.ev & ~pwdata[1:0];
      end
    end

    // GPI or sequencer edges set and clear enable and select bits.
    en_v  = {next_s.ldo_en, next_s.buck_en};
    sel_v = {next_s.ldo_sel, next_s.buck_sel};
    for (int r = 0; r < 8; r++) begin
      e = ctl_edge(s.en_src[2*r+:2], gpi_m, gpi_p, seq_enable[r], s.seq_en_q[r]);
      if (e[1]) begin
        en_v[r] = 1'b1;
      end else if (e[0]) begin
        en_v[r] = 1'b0;
      end
      e = ctl_edge(s.sel_src[2*r+:2], gpi_m, gpi_p, seq_select[r], s.seq_sel_q[r]);
      if (e[1]) begin
        sel_v[r] = 1'b1;
      end else if (e[0]) begin
        sel_v[r] = 1'b0;
      end
    end

    // Over-current timing per LDO; counters measure continuous excess only.
    for (int j = 0; j < 4; j++) begin
      if (!s.ilim_s[1][j]) begin
        next_s.oc_cnt[j] = '0;
      end else if (s.oc_cnt[j] != SD_MX) begin
        next_s.oc_cnt[j] = s.oc_cnt[j] + 1'b1;
      end
      if (s.ilim_s[1][j] && s.oc_cnt[j] == EV_M1) begin
        next_s.ev_lim_p = 1'b1;
        next_s.ev[rcl_pkg::EV_LIM] = 1'b1;
      end
      if (s.ilim_s[1][j] && s.oc_cnt[j] == SD_M1 && s.ctrl[rcl_pkg::CTRL_SD]) begin
        en_v[4+j] = 1'b0;
      end
    end
    {next_s.ldo_en, next_s.buck_en}   = en_v;
    {next_s.ldo_sel, next_s.buck_sel} = sel_v;

    // Shared step timer; one code per tick for every buck.
    if (tick) begin
      next_s.slew_cnt = 16'((32'(s.ctrl[rcl_pkg::CTRL_SLEW+:4]) + 1) *
                            rcl_pkg::SLEW_UNIT_CYC - 1);
    end else begin
      next_s.slew_cnt = s.slew_cnt - 16'h0001;
    end
    for (int i = 0; i < 4; i++) begin
      next_s.run[i] = on[i];
      if (on[i] && !s.run[i] && !s.ctrl[rcl_pkg::CTRL_SLOW]) begin
        next_s.vcode[i] = tgt[i];
      end else if (on[i] && tick) begin
        next_s.vcode[i] = step_to(s.vcode[i], tgt[i]);
      end else if (!on[i] && s.ctrl[rcl_pkg::CTRL_DISCH] && tick) begin
        next_s.vcode[i] = step_to(s.vcode[i], 8'h00);
      end else if (!on[i] && !s.ctrl[rcl_pkg::CTRL_DISCH]) begin
        next_s.vcode[i] = 8'h00;
      end
    end

    // Ready fires one cycle after all bucks first agree with their targets.
    next_s.all_rdy_q = &at_tgt;
    if (&at_tgt && !s.all_rdy_q) begin
      next_s.ev_rdy_p = 1'b1;
      next_s.ev[rcl_pkg::EV_RDY] = 1'b1;
    end
  end

  // ==========================================================================
  // State register

  // Reset loads constants only; ready history starts high to avoid a spurious event.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.ctrl      <= rcl_pkg::CTRL_RST;
      s.buck_cfg  <= {4{rcl_pkg::CFG_RST}};
      s.ldo_cfg   <= {4{rcl_pkg::CFG_RST}};
      s.all_rdy_q <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Checks

  pin1_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gpio1_analog && s.en_src[1:0] == 2'd1 && !wr) |=> $stable(s.buck_en[0]))
    else $error("GPI on an analog pin changed an enable");
  volt_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !mode_active && paddr == 8'h18) |=> $stable(s.buck_cfg[2][15:0]))
    else $error("Buck voltage written outside ACTIVE mode");
  oc_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    linreg_overcurrent_event |-> $past(|s.ilim_s[1]))
    else $error("Over-current event without a comparator");
  oc_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.ilim_s[1][0] |=> s.oc_cnt[0] == '0)
    else $error("Over-current counter kept counting");
  oc_shutdown_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.ilim_s[1][0] && s.oc_cnt[0] == SD_M1 && s.ctrl[0]) |=> !s.ldo_en[0])
    else $error("LDO not shut down after long over-current");
  slew_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.run[1] && $past(s.run[1]) && s.vcode[1] != $past(s.vcode[1])) |->
    (s.vcode[1] == $past(s.vcode[1]) + 8'd1 || s.vcode[1] == $past(s.vcode[1]) - 8'd1))
    else $error("Buck code jumped more than one step");
  ramp_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    ramp_ready_event |-> $past(&at_tgt) && !$past(&at_tgt, 2))
    else $error("Ramp ready without all bucks at target");
  always_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_reset && s.ctrl[5]) |-> ldo_enable_out[0] && (!buck_enable_out[1] || s.vcode[1] != 8'h00))
    else $error("Always-on LDO1 dropped in RESET mode");

endmodule // rcl_regulator_ctrl

`default_nettype wire

// File: tb/rcl_far_model.sv
// Far-side model: GPI levels, sequencer and mode lines, and the LDO comparators.
// Assumes one bench process calls its tasks; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module rcl_far_model (
  input  wire logic  pclk,
  output logic       mode_active,
  output logic       mode_reset,
  output logic [7:0] seq_enable,
  output logic [7:0] seq_select,
  output logic [2:0] gpi_level,
  output logic [3:0] ldo_ilim_cmp,
  output logic [3:0] ldo_ovp_cmp
);
  // ==========================================================================
  // Idle levels at time zero: device active, every other line passive.
  initial begin
    mode_active  = 1'b1;
    mode_reset   = 1'b0;
    seq_enable   = 8'h00;
    seq_select   = 8'h00;
    gpi_level    = 3'b000;
    ldo_ilim_cmp = 4'h0;
    ldo_ovp_cmp  = 4'h0;
  end

  // Levels change right after an edge so the synchronisers see one clean step.
  task automatic drive(input logic [2:0] gpi, input logic [3:0] ilim, input logic [3:0] ovp, input logic [7:0] seq);
    @(posedge pclk);
    gpi_level    <= gpi;
    ldo_ilim_cmp <= ilim;
    ldo_ovp_cmp  <= ovp;
    seq_enable   <= seq;
  endtask

  // Power mode of the device as the sequencer reports it.
  task automatic set_mode(input logic act, input logic rst);
    @(posedge pclk);
    mode_active <= act;
    mode_reset  <= rst;
  endtask
endmodule // rcl_far_model
`default_nettype wire

// File: tb/regulator_control_logic_tb.sv
// Self-checking bench for the regulator control logic, driven over APB and the far-side pins.
// Assumes rcl_far_model on the pins; shortened over-current counts of 20 and 60 cycles.
`timescale 1ns/1ps
`default_nettype none
module regulator_control_logic_tb;
  // ==========================================================================
  // Signals
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} rcl_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, seq_enable, seq_select, buck_op_mode, switcher_current_limit;
  logic [31:0] pwdata, prdata, buck_vcode, ldo_vcode, rdv;
  logic [3:0]  buck_enable_out, buck_sleep, ldo_enable_out, ldo_sleep, ldo_pulldown, ilim, ovp;
  logic [2:0]  gpi;
  logic        mode_active, mode_reset, slow, fc1, fc2, ga0, ga1, rdy_ev, oc_ev;
  int          bad_count, cmp_count, n, ev_at, off_at;
  rcl_row_t    rows [7];

  // ==========================================================================
  // Design and far side
  rcl_regulator_ctrl #(.OC_EVENT_CYC(20), .OC_SD_CYC(60)) i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_active(mode_active),
    .mode_reset(mode_reset), .seq_enable(seq_enable), .seq_select(seq_select), .gpi_level(gpi),
    .ldo_ilim_cmp(ilim), .ldo_ovp_cmp(ovp), .buck_enable_out(buck_enable_out), .buck_vcode(buck_vcode),
    .buck_sleep(buck_sleep), .buck_op_mode(buck_op_mode), .switcher_current_limit(switcher_current_limit),
    .slow_startup_select(slow), .switcher1_full_current(fc1), .switcher2_full_current(fc2),
    .ldo_enable_out(ldo_enable_out), .ldo_vcode(ldo_vcode), .ldo_sleep(ldo_sleep),
    .ldo_pulldown(ldo_pulldown), .gpio0_analog(ga0), .gpio1_analog(ga1), .ramp_ready_event(rdy_ev),
    .linreg_overcurrent_event(oc_ev));
  rcl_far_model i_far (
    .pclk(pclk), .mode_active(mode_active), .mode_reset(mode_reset), .seq_enable(seq_enable),
    .seq_select(seq_select), .gpi_level(gpi), .ldo_ilim_cmp(ilim), .ldo_ovp_cmp(ovp));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================================
  // Helpers: one APB transfer held until pready, compare, verdict.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang ends the run well after the expected run of under two thousand cycles.
  initial begin
    #400_000;
    bad_count++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence: reset, register table, then the timing and pin cases.
  initial begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    presetn   = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    rows = '{'{rcl_pkg::ADDR_ENSRC, 32'hFFFF_FFFF, 32'h0000_FFFF}, '{rcl_pkg::ADDR_ENSRC, 32'h0, 32'h0},
             '{rcl_pkg::ADDR_SELSRC, 32'hFFFF_FFFF, 32'h0000_FFFF}, '{rcl_pkg::ADDR_SELSRC, 32'h0, 32'h0},
             '{8'h14, 32'hFFFF_FFFF, 32'h003F_FFFF}, '{8'h24, 32'hFFFF_FFFF, 32'h0007_FFFF},
             '{8'h3C, 32'h1234_5678, 32'h0000_0000}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(rcl_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
    chk(rdv, rcl_pkg::CTRL_RST);
    chk({fc1, fc2, slow}, 3'b110);
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    wait_cyc(1);
    chk({fc1, fc2}, 2'b00);
    // Write then read back each row; the last row is an unmapped place.
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].w);
      apb(rows[i].a, 1'b0, 32'h0000_0000);
      chk(rdv, rows[i].e);
    end
    chk(perr, 1'b1);
    chk({switcher_current_limit[3:2], buck_op_mode[3:2], ldo_vcode[15:8]}, 12'hFFF);
    // Voltage fields refuse writes outside ACTIVE mode, accept them inside.
    i_far.set_mode(1'b0, 1'b0);
    apb(8'h18, 1'b1, 32'h0000_1234);
    apb(8'h18, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000);
    i_far.set_mode(1'b1, 1'b0);
    apb(8'h18, 1'b1, 32'h0000_1234);
    apb(8'h18, 1'b0, 32'h0000_0000);
    chk(rdv, 32'h0000_1234);
    // Fast start jumps to code 5, then three steps of 100 cycles reach 8.
    apb(8'h14, 1'b1, 32'h0000_0005);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0002);
    wait_cyc(4);
    chk(buck_vcode[15:8], 8'h05);
    apb(8'h14, 1'b1, 32'h0000_0008);
    n = 0;
    while (rdy_ev !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 200 && n <= 320, 1'b1);
    chk(buck_vcode[15:8], 8'h08);
    // Discharge on switch-off walks eight codes down before the enable drops.
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0005);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0000);
    n = 0;
    while (buck_enable_out[1] === 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= 690 && n <= 820, 1'b1);
    chk(buck_vcode[15:8], 8'h00);
    // Sleep follows whichever setting is active.
    apb(8'h14, 1'b1, 32'h0001_0008);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0002);
    wait_cyc(1);
    chk(buck_sleep[1], 1'b1);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0202);
    wait_cyc(1);
    chk(buck_sleep[1], 1'b0);
    apb(8'h20, 1'b1, 32'h0002_0000);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_1010);
    wait_cyc(1);
    chk({ldo_sleep[0], ldo_enable_out[0]}, 2'b11);
    // RESET mode keeps only the always-on LDO1.
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0021);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0050);
    i_far.set_mode(1'b1, 1'b1);
    wait_cyc(2);
    chk(ldo_enable_out, 4'b0001);
    i_far.set_mode(1'b1, 1'b0);
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0010);
    // A short burst restarts the count; a long one raises the event, then shuts LDO1.
    i_far.drive(3'b000, 4'b0001, 4'b0000, 8'h00);
    n = 0;
    repeat (12) begin
      @(posedge pclk);
      n += int'(oc_ev === 1'b1);
    end
    i_far.drive(3'b000, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    chk(n, 0);
    i_far.drive(3'b000, 4'b0001, 4'b0000, 8'h00);
    ev_at = -1;
    off_at = -1;
    for (n = 0; n < 100; n++) begin
      @(posedge pclk);
      if (oc_ev === 1'b1 && ev_at < 0) ev_at = n;
      if (ldo_enable_out[0] !== 1'b1 && off_at < 0) off_at = n;
    end
    chk(ev_at >= 19 && ev_at <= 27, 1'b1);
    chk(off_at >= 58 && off_at <= 68, 1'b1);
    apb(rcl_pkg::ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk(rdv[0], 1'b1);
    apb(rcl_pkg::ADDR_EN, 1'b0, 32'h0000_0000);
    chk(rdv[4], 1'b0);
    // Over-voltage pull-down on the re-enabled LDO1, then disabled per LDO.
    apb(rcl_pkg::ADDR_EN, 1'b1, 32'h0000_0010);
    i_far.drive(3'b000, 4'b0000, 4'b0001, 8'h00);
    wait_cyc(4);
    chk({ldo_enable_out[0], ldo_pulldown[0]}, 2'b11);
    apb(8'h20, 1'b1, 32'h0006_0000);
    wait_cyc(1);
    chk(ldo_pulldown[0], 1'b0);
    // Analog use of pins 0 and 1 masks GPI1; unmasked, its edges drive the enable.
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0019);
    apb(rcl_pkg::ADDR_ENSRC, 1'b1, 32'h0000_0001);
    i_far.drive(3'b001, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    chk({ga0, ga1, buck_enable_out[0]}, 3'b110);
    i_far.drive(3'b000, 4'b0000, 4'b0000, 8'h00);
    apb(rcl_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    i_far.drive(3'b001, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    chk(buck_enable_out[0], 1'b1);
    i_far.drive(3'b000, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    chk(buck_enable_out[0], 1'b0);
    // GPI2 edges set and clear the buck1 select bit.
    apb(rcl_pkg::ADDR_SELSRC, 1'b1, 32'h0000_0002);
    i_far.drive(3'b010, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    apb(rcl_pkg::ADDR_EN, 1'b0, 32'h0000_0000);
    chk(rdv[8], 1'b1);
    i_far.drive(3'b000, 4'b0000, 4'b0000, 8'h00);
    wait_cyc(4);
    apb(rcl_pkg::ADDR_EN, 1'b0, 32'h0000_0000);
    chk(rdv[8], 1'b0);
    // Sequencer step enables LDO2 when no GPI owns it.
    apb(rcl_pkg::ADDR_ENSRC, 1'b1, 32'h0000_0000);
    i_far.drive(3'b000, 4'b0000, 4'b0000, 8'h20);
    wait_cyc(3);
    chk(ldo_enable_out[1], 1'b1);
    print_verdict();
  end
endmodule // regulator_control_logic_tb
`default_nettype wire
